// ===== logic/rps_top.sv
// Notes on behaviour
// [RQ1] up to sixteen remappable pins carry remapped peripheral inputs and outputs
// [RQ2] each peripheral input has a 5-bit selector choosing its pin
// [RQ3] fourteen selectable inputs: irqs, timer clocks, captures, fault, serial, spi
// [RQ4] each pin has a 5-bit selector choosing the peripheral output
// [RQ5] output code zero leaves the pin with its port function
// [RQ6] code 3 routes serial transmit, code 4 serial request-to-send
// [RQ7] codes 7, 8, 9 route spi data, clock, select outputs
// [RQ8] codes 18 and 19 route compare outputs a and b
// [RQ9] remapped peripherals have no default pin, only software selection; inputs here reset to pin 0
// [RQ10] an active remapped output wins over port and other digital functions
// [RQ11] analog use of a pin always wins over remapping
// [RQ12] any mix of selections is accepted, no interlocks
// [RQ13] while locked, selector writes finish but change nothing
// [RQ14] lock bit is bit 6 of oscillator control; set blocks writes
// [RQ15] software writes 45h, 67h, then the lock value in one write
// [RQ16] lock holds its value until the next valid sequence
// [RQ17] shadow copies are compared continuously; mismatch raises a reset
// [RQ18] one-way option refuses clearing the lock once it was set
// [RQ19] one-way option is active unprogrammed; programmed allows many sessions
// [RQ20] all selectors reset to zero: inputs pin 0, outputs disconnected
// [RQ21] lock resets unlocked so writes work straight after reset
// [RQ22] input code 11111 ties to ground; 0 to 15 pick pins
// [RQ23] key writes and lock write must be consecutive writes, else abort
`include "rps_params.svh"

module rps_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register write port
   input wire logic wr_en,
   input wire logic [5:0] wr_addr,
   input wire logic [15:0] wr_data,
   // register read port
   input wire logic [5:0] rd_addr,
   output logic [15:0] rd_data,
   // configuration word
   input wire logic one_way_lock_option,
   // pins
   input wire logic [15:0] pin_in,
   input wire logic [15:0] analog_sel,
   input wire logic [15:0] port_out,
   input wire logic [15:0] port_oe,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe,
   // peripheral outputs to route
   input wire logic serial_transmit_out,
   input wire logic serial_request_to_send_out,
   input wire logic spi_data_out,
   input wire logic spi_clock_out,
   input wire logic spi_select_out,
   input wire logic compare_out_a,
   input wire logic compare_out_b,
   // peripheral inputs routed from pins
   output logic ext_irq_one,
   output logic ext_irq_two,
   output logic timer_b_clock_in,
   output logic timer_c_clock_in,
   output logic capture_ch_a,
   output logic capture_ch_b,
   output logic capture_ch_g,
   output logic capture_ch_h,
   output logic compare_fault_a,
   output logic serial_receive_in,
   output logic serial_clear_to_send_in,
   output logic spi_data_in,
   output logic spi_clock_in,
   output logic spi_select_in,
   // status
   output logic pin_map_lock,
   output logic cfg_mismatch_rst
);

   // ----------------------------------------
   // field map
   // ----------------------------------------
   function automatic logic [5:0] in_reg_addr(input int idx);
      case (idx)
         0: in_reg_addr = `RPS_ADDR_IN0;
         1: in_reg_addr = `RPS_ADDR_IN1;
         2, 3: in_reg_addr = `RPS_ADDR_IN3;
         4, 5: in_reg_addr = `RPS_ADDR_IN7;
         6, 7: in_reg_addr = `RPS_ADDR_IN10;
         8: in_reg_addr = `RPS_ADDR_IN11;
         9, 10: in_reg_addr = `RPS_ADDR_IN18;
         11, 12: in_reg_addr = `RPS_ADDR_IN20;
         default: in_reg_addr = `RPS_ADDR_IN21;
      endcase
   endfunction : in_reg_addr

   function automatic logic in_is_hi(input int idx);
      case (idx)
         0, 3, 5, 7, 10, 12: in_is_hi = 1'b1;
         default: in_is_hi = 1'b0;
      endcase
   endfunction : in_is_hi

   function automatic logic [5:0] out_reg_addr(input int pin);
      out_reg_addr = `RPS_OUT_BASE + 6'(pin >> 1);
   endfunction : out_reg_addr

   function automatic rps_pkg::rps_sel_t pick_field(input logic [15:0] d, input logic hi);
      pick_field = hi ? d[`RPS_HI_LSB +: `RPS_SEL_W] : d[`RPS_LO_LSB +: `RPS_SEL_W];
   endfunction : pick_field

   // ----------------------------------------
   // state
   // ----------------------------------------
   rps_pkg::rps_sel_t in_sel_ff [0:`RPS_NUM_IN-1];
   rps_pkg::rps_sel_t nxt_in_sel [0:`RPS_NUM_IN-1];
   rps_pkg::rps_sel_t out_sel_ff [0:`RPS_NUM_PINS-1];
   rps_pkg::rps_sel_t nxt_out_sel [0:`RPS_NUM_PINS-1];
   rps_pkg::rps_sel_t in_shadow_ff [0:`RPS_NUM_IN-1];
   rps_pkg::rps_sel_t out_shadow_ff [0:`RPS_NUM_PINS-1];
   rps_pkg::rps_key_e key_ff;
   rps_pkg::rps_key_e nxt_key;
   logic lock_ff;
   logic nxt_lock;
   logic set_once_ff;
   logic nxt_set_once;
   logic one_way_ff;
   logic [15:0] pin_meta_ff;
   logic [15:0] pin_sync_ff;
   logic [15:0] rd_data_ff;
   logic [15:0] nxt_rd_data;
   logic [15:0] pin_out_ff;
   logic [15:0] nxt_pin_out;
   logic [15:0] pin_oe_ff;
   logic [15:0] nxt_pin_oe;
   logic [`RPS_NUM_IN-1:0] periph_in_ff;
   logic [`RPS_NUM_IN-1:0] in_val;
   logic [15:0] out_drv;
   logic [15:0] out_val;
   logic mismatch;
   logic mismatch_ff;

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
   end

   // ----------------------------------------
   // selector writes and lock sequence
   // ----------------------------------------
   always_comb begin
      nxt_in_sel = in_sel_ff;
      nxt_out_sel = out_sel_ff;
      nxt_key = key_ff;
      nxt_lock = lock_ff;
      nxt_set_once = set_once_ff;
      if (wr_en) begin
         if (wr_addr == `RPS_OSC_ADDR) begin
            case (key_ff) // [RQ15]
               rps_pkg::RPS_KEY_TWO: begin
                  nxt_key = rps_pkg::RPS_KEY_IDLE;
                  if (wr_data[`RPS_LOCK_BIT]) begin // [RQ14]
                     nxt_lock = 1'b1;
                     nxt_set_once = 1'b1;
                  end else if (!(one_way_ff && set_once_ff)) begin // [RQ18] [RQ19]
                     nxt_lock = 1'b0;
                  end
               end
               rps_pkg::RPS_KEY_ONE: begin
                  if (wr_data[7:0] == `RPS_KEY_SECOND) begin
                     nxt_key = rps_pkg::RPS_KEY_TWO;
                  end else if (wr_data[7:0] == `RPS_KEY_FIRST) begin
                     nxt_key = rps_pkg::RPS_KEY_ONE;
                  end else begin
                     nxt_key = rps_pkg::RPS_KEY_IDLE; // [RQ23]
                  end
               end
               default: begin
                  if (wr_data[7:0] == `RPS_KEY_FIRST) begin
                     nxt_key = rps_pkg::RPS_KEY_ONE;
                  end else begin
                     nxt_key = rps_pkg::RPS_KEY_IDLE;
                  end
               end
            endcase
         end else begin
            nxt_key = rps_pkg::RPS_KEY_IDLE; // [RQ23]
            if (!lock_ff) begin // [RQ13]
               for (int i = 0; i < `RPS_NUM_IN; i++) begin
                  if (wr_addr == in_reg_addr(i)) begin
                     nxt_in_sel[i] = pick_field(wr_data, in_is_hi(i)); // [RQ2] [RQ12]
                  end
               end
               for (int p = 0; p < `RPS_NUM_PINS; p++) begin
                  if (wr_addr == out_reg_addr(p)) begin
                     nxt_out_sel[p] = pick_field(wr_data, p[0]); // [RQ4] [RQ12]
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < `RPS_NUM_IN; i++) begin
            in_sel_ff[i] <= `RPS_SEL_RESET; // [RQ20]
            in_shadow_ff[i] <= `RPS_SEL_RESET;
         end
         for (int p = 0; p < `RPS_NUM_PINS; p++) begin
            out_sel_ff[p] <= `RPS_SEL_RESET; // [RQ20] [RQ9]
            out_shadow_ff[p] <= `RPS_SEL_RESET;
         end
         key_ff <= rps_pkg::RPS_KEY_IDLE;
         lock_ff <= 1'b0; // [RQ21]
         set_once_ff <= 1'b0;
         one_way_ff <= one_way_lock_option; // [RQ19]
      end else begin
         in_sel_ff <= nxt_in_sel;
         out_sel_ff <= nxt_out_sel;
         in_shadow_ff <= nxt_in_sel; // [RQ17]
         out_shadow_ff <= nxt_out_sel;
         key_ff <= nxt_key;
         lock_ff <= nxt_lock; // [RQ16]
         set_once_ff <= nxt_set_once;
      end
   end

   // ----------------------------------------
   // shadow comparison
   // ----------------------------------------
   always_comb begin
      mismatch = 1'b0;
      for (int i = 0; i < `RPS_NUM_IN; i++) begin
         if (in_sel_ff[i] != in_shadow_ff[i]) begin
            mismatch = 1'b1; // [RQ17]
         end
      end
      for (int p = 0; p < `RPS_NUM_PINS; p++) begin
         if (out_sel_ff[p] != out_shadow_ff[p]) begin
            mismatch = 1'b1; // [RQ17]
         end
      end
   end

   // ----------------------------------------
   // input and output muxes
   // ----------------------------------------
   for (genvar i = 0; i < `RPS_NUM_IN; i++) begin : g_in
      rps_in_mux u_in (
         .pin_val(pin_sync_ff),
         .analog_sel(analog_sel),
         .sel(in_sel_ff[i]),
         .value(in_val[i])
      ); // [RQ3]
   end

   for (genvar p = 0; p < `RPS_NUM_PINS; p++) begin : g_out
      rps_out_mux u_out (
         .sel(out_sel_ff[p]),
         .serial_transmit_out(serial_transmit_out),
         .serial_request_to_send_out(serial_request_to_send_out),
         .spi_data_out(spi_data_out),
         .spi_clock_out(spi_clock_out),
         .spi_select_out(spi_select_out),
         .compare_out_a(compare_out_a),
         .compare_out_b(compare_out_b),
         .drive(out_drv[p]),
         .value(out_val[p])
      ); // [RQ1]
   end

   // ----------------------------------------
   // pin priority and readback
   // ----------------------------------------
   always_comb begin
      for (int p = 0; p < `RPS_NUM_PINS; p++) begin
         if (analog_sel[p]) begin // [RQ11]
            nxt_pin_out[p] = 1'b0;
            nxt_pin_oe[p] = 1'b0;
         end else if (out_drv[p]) begin // [RQ10]
            nxt_pin_out[p] = out_val[p];
            nxt_pin_oe[p] = 1'b1;
         end else begin // [RQ5]
            nxt_pin_out[p] = port_out[p];
            nxt_pin_oe[p] = port_oe[p];
         end
      end
      nxt_rd_data = '0;
      for (int i = 0; i < `RPS_NUM_IN; i++) begin
         if (rd_addr == in_reg_addr(i)) begin
            if (in_is_hi(i)) begin
               nxt_rd_data[`RPS_HI_LSB +: `RPS_SEL_W] = in_sel_ff[i];
            end else begin
               nxt_rd_data[`RPS_LO_LSB +: `RPS_SEL_W] = in_sel_ff[i];
            end
         end
      end
      for (int p = 0; p < `RPS_NUM_PINS; p++) begin
         if (rd_addr == out_reg_addr(p)) begin
            if (p[0]) begin
               nxt_rd_data[`RPS_HI_LSB +: `RPS_SEL_W] = out_sel_ff[p];
            end else begin
               nxt_rd_data[`RPS_LO_LSB +: `RPS_SEL_W] = out_sel_ff[p];
            end
         end
      end
      if (rd_addr == `RPS_OSC_ADDR) begin
         nxt_rd_data[`RPS_LOCK_BIT] = lock_ff; // [RQ14]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_out_ff <= '0;
         pin_oe_ff <= '0;
         periph_in_ff <= '0;
         rd_data_ff <= '0;
         mismatch_ff <= 1'b0;
      end else begin
         pin_out_ff <= nxt_pin_out;
         pin_oe_ff <= nxt_pin_oe;
         periph_in_ff <= in_val;
         rd_data_ff <= nxt_rd_data;
         mismatch_ff <= mismatch;
      end
   end

   assign pin_out = pin_out_ff;
   assign pin_oe = pin_oe_ff;
   assign rd_data = rd_data_ff;
   assign pin_map_lock = lock_ff;
   assign cfg_mismatch_rst = mismatch_ff;
   assign ext_irq_one = periph_in_ff[0];
   assign ext_irq_two = periph_in_ff[1];
   assign timer_b_clock_in = periph_in_ff[2];
   assign timer_c_clock_in = periph_in_ff[3];
   assign capture_ch_a = periph_in_ff[4];
   assign capture_ch_b = periph_in_ff[5];
   assign capture_ch_g = periph_in_ff[6];
   assign capture_ch_h = periph_in_ff[7];
   assign compare_fault_a = periph_in_ff[8];
   assign serial_receive_in = periph_in_ff[9];
   assign serial_clear_to_send_in = periph_in_ff[10];
   assign spi_data_in = periph_in_ff[11];
   assign spi_clock_in = periph_in_ff[12];
   assign spi_select_in = periph_in_ff[13];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   chk_locked_write_kept: assert property ( // [RQ13]
      lock_ff && wr_en && wr_addr == `RPS_OUT_BASE |=> $stable(out_sel_ff[0]))
      else $error("selector changed while locked");
   chk_reset_sel_zero: assert property ( // [RQ20]
      $past(sys_rst) |-> out_sel_ff[0] == `RPS_OUT_NULL && in_sel_ff[0] == `RPS_SEL_RESET)
      else $error("selector not zero after reset");
   chk_reset_unlocked: assert property ( // [RQ21]
      $past(sys_rst) |-> !lock_ff)
      else $error("lock set after reset");
   chk_key_sets_lock: assert property ( // [RQ15]
      wr_en && wr_addr == `RPS_OSC_ADDR && wr_data[7:0] == `RPS_KEY_FIRST ##1
      wr_en && wr_addr == `RPS_OSC_ADDR && wr_data[7:0] == `RPS_KEY_SECOND ##1
      wr_en && wr_addr == `RPS_OSC_ADDR && wr_data[`RPS_LOCK_BIT] |=> lock_ff)
      else $error("key sequence did not set lock");
   chk_seq_abort: assert property ( // [RQ23]
      key_ff != rps_pkg::RPS_KEY_IDLE && wr_en && wr_addr != `RPS_OSC_ADDR
      |=> key_ff == rps_pkg::RPS_KEY_IDLE)
      else $error("sequence survived foreign write");
   chk_one_way_hold: assert property ( // [RQ18]
      one_way_ff && set_once_ff && lock_ff |=> lock_ff)
      else $error("one-way lock cleared");
   chk_lock_hold: assert property ( // [RQ16]
      !wr_en |=> $stable(lock_ff))
      else $error("lock changed without write");
   chk_analog_wins: assert property ( // [RQ11]
      analog_sel[3] |=> !pin_oe_ff[3])
      else $error("analog pin driven");
   chk_null_port: assert property ( // [RQ5]
      !analog_sel[1] && out_sel_ff[1] == `RPS_OUT_NULL
      |=> pin_oe_ff[1] == $past(port_oe[1]) && pin_out_ff[1] == $past(port_out[1]))
      else $error("null code did not give port");
   chk_tx_route: assert property ( // [RQ6]
      !analog_sel[3] && out_sel_ff[3] == `RPS_OUT_TX
      |=> pin_oe_ff[3] && pin_out_ff[3] == $past(serial_transmit_out))
      else $error("transmit not routed");
   chk_tie_ground: assert property ( // [RQ22]
      in_sel_ff[13] == `RPS_TIE_GND |=> !spi_select_in)
      else $error("tied input not low");
   chk_shadow_reset: assert property ( // [RQ17]
      mismatch |=> cfg_mismatch_rst)
      else $error("mismatch not reported");

   cov_unlock_session: cover property (lock_ff ##1 !lock_ff);
   cov_tx_on_pin: cover property (out_sel_ff[3] == `RPS_OUT_TX && pin_oe_ff[3]);
   cov_rx_from_pin: cover property (in_sel_ff[9] == 5'h0a && serial_receive_in);

endmodule : rps_top

// ===== logic/rps_params.svh
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define RPS_SEL_W 5
`define RPS_NUM_PINS 16
`define RPS_NUM_IN 14
`define RPS_NUM_OUT_REG 8
`define RPS_ADDR_W 6
`define RPS_DATA_W 16

// ----------------------------------------
// field positions
// ----------------------------------------
`define RPS_LO_LSB 0
`define RPS_HI_LSB 8
`define RPS_LOCK_BIT 6

// ----------------------------------------
// register indices
// ----------------------------------------
`define RPS_ADDR_IN0 6'h00
`define RPS_ADDR_IN1 6'h01
`define RPS_ADDR_IN3 6'h03
`define RPS_ADDR_IN7 6'h07
`define RPS_ADDR_IN10 6'h0a
`define RPS_ADDR_IN11 6'h0b
`define RPS_ADDR_IN18 6'h12
`define RPS_ADDR_IN20 6'h14
`define RPS_ADDR_IN21 6'h15
`define RPS_OUT_BASE 6'h20
`define RPS_OSC_ADDR 6'h3f

// ----------------------------------------
// codes and keys
// ----------------------------------------
`define RPS_SEL_RESET 5'h00
`define RPS_TIE_GND 5'h1f
`define RPS_OUT_NULL 5'h00
`define RPS_OUT_TX 5'h03
`define RPS_OUT_RTS 5'h04
`define RPS_OUT_SDO 5'h07
`define RPS_OUT_SCK 5'h08
`define RPS_OUT_SS 5'h09
`define RPS_OUT_OC1 5'h12
`define RPS_OUT_OC2 5'h13
`define RPS_KEY_FIRST 8'h45
`define RPS_KEY_SECOND 8'h67

`endif

// ===== logic/rps_pkg.sv
package rps_pkg;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef logic [4:0] rps_sel_t;

   typedef enum logic [1:0] {
      RPS_KEY_IDLE = 2'b00,
      RPS_KEY_ONE = 2'b01,
      RPS_KEY_TWO = 2'b10
   } rps_key_e;

endpackage : rps_pkg

// ===== logic/rps_in_mux.sv
`include "rps_params.svh"

module rps_in_mux (
   // pin side
   input wire logic [15:0] pin_val,
   input wire logic [15:0] analog_sel,
   // selector
   input wire rps_pkg::rps_sel_t sel,
   // peripheral side
   output logic value
);

   // ----------------------------------------
   // pick one pin, else ground
   // ----------------------------------------
   always_comb begin
      value = 1'b0;
      if (sel < 5'(`RPS_NUM_PINS)) begin // [RQ22]
         if (!analog_sel[sel[3:0]]) begin // [RQ11]
            value = pin_val[sel[3:0]]; // [RQ2]
         end
      end
   end

endmodule : rps_in_mux

// ===== logic/rps_out_mux.sv
`include "rps_params.svh"

module rps_out_mux (
   // selector
   input wire rps_pkg::rps_sel_t sel,
   // peripheral outputs
   input wire logic serial_transmit_out,
   input wire logic serial_request_to_send_out,
   input wire logic spi_data_out,
   input wire logic spi_clock_out,
   input wire logic spi_select_out,
   input wire logic compare_out_a,
   input wire logic compare_out_b,
   // pin side
   output logic drive,
   output logic value
);

   // ----------------------------------------
   // code to peripheral output
   // ----------------------------------------
   always_comb begin
      drive = 1'b1;
      value = 1'b0;
      case (sel) // [RQ4]
         `RPS_OUT_TX: value = serial_transmit_out; // [RQ6]
         `RPS_OUT_RTS: value = serial_request_to_send_out; // [RQ6]
         `RPS_OUT_SDO: value = spi_data_out; // [RQ7]
         `RPS_OUT_SCK: value = spi_clock_out; // [RQ7]
         `RPS_OUT_SS: value = spi_select_out; // [RQ7]
         `RPS_OUT_OC1: value = compare_out_a; // [RQ8]
         `RPS_OUT_OC2: value = compare_out_b; // [RQ8]
         default: drive = 1'b0; // [RQ5]
      endcase
   end

endmodule : rps_out_mux

// ===== tb/rps_far_model.sv
module rps_far_model (
   // bench control
   input wire logic [15:0] pad_level,
   input wire logic [6:0] per_level,
   // toward the block
   output logic [15:0] pin_in,
   output logic [6:0] per_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // pads and peripheral outputs
   // ----------------------------------------
   assign pin_in = pad_level;
   assign per_out = per_level;
endmodule : rps_far_model

// ===== tb/remappable_pin_select_tb_top.sv
`include "rps_params.svh"

module remappable_pin_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // signals and tables
   // ----------------------------------------
   logic clk_sys = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, one_way = 1'b0;
   logic [5:0] wr_addr = 6'h00, rd_addr = 6'h00;
   logic [15:0] wr_data = 16'h0000, rd_data, analog_sel = 16'h0000;
   logic [15:0] port_out = 16'h0000, port_oe = 16'h0000, pad_level = 16'h0000;
   logic [15:0] pin_in, pin_out, pin_oe, d;
   logic [6:0] per_level = 7'h00, per_out;
   logic [13:0] ins;
   logic pin_map_lock, cfg_mismatch_rst;
   int n_mismatch = 0, checks = 0, cyc_n = 0, pin;
   localparam logic [5:0] IN_A [14] = '{6'h00, 6'h01, 6'h03, 6'h03, 6'h07, 6'h07, 6'h0a,
      6'h0a, 6'h0b, 6'h12, 6'h12, 6'h14, 6'h14, 6'h15};
   localparam logic [13:0] IN_HI = 14'h14a9;
   localparam logic [4:0] OCODE [10] = '{`RPS_OUT_NULL, `RPS_OUT_TX, `RPS_OUT_RTS,
      `RPS_OUT_SDO, `RPS_OUT_SCK, `RPS_OUT_SS, `RPS_OUT_OC1, `RPS_OUT_OC2, 5'h01, 5'h1f};
   localparam logic [6:0] OHOT [10] = '{7'h00, 7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02,
      7'h01, 7'h00, 7'h00};

   always #10 clk_sys = ~clk_sys;

   rps_far_model far_u (.pad_level(pad_level), .per_level(per_level), .pin_in(pin_in),
      .per_out(per_out));

   rps_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
      .one_way_lock_option(one_way), .pin_in(pin_in), .analog_sel(analog_sel),
      .port_out(port_out), .port_oe(port_oe), .pin_out(pin_out), .pin_oe(pin_oe),
      .serial_transmit_out(per_out[6]), .serial_request_to_send_out(per_out[5]),
      .spi_data_out(per_out[4]), .spi_clock_out(per_out[3]), .spi_select_out(per_out[2]),
      .compare_out_a(per_out[1]), .compare_out_b(per_out[0]),
      .ext_irq_one(ins[13]), .ext_irq_two(ins[12]), .timer_b_clock_in(ins[11]),
      .timer_c_clock_in(ins[10]), .capture_ch_a(ins[9]), .capture_ch_b(ins[8]),
      .capture_ch_g(ins[7]), .capture_ch_h(ins[6]), .compare_fault_a(ins[5]),
      .serial_receive_in(ins[4]), .serial_clear_to_send_in(ins[3]), .spi_data_in(ins[2]),
      .spi_clock_in(ins[1]), .spi_select_in(ins[0]), .pin_map_lock(pin_map_lock),
      .cfg_mismatch_rst(cfg_mismatch_rst));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   always @(posedge clk_sys) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string w);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, w, got, exp);
      end
   endtask : chk_word

   task automatic chk_flag(input logic got, input logic exp, input string w);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %b exp %b", $time, w, got, exp);
      end
   endtask : chk_flag

   task automatic wr(input logic [5:0] a, input logic [15:0] v);
      wr_en = 1'b1;
      wr_addr = a;
      wr_data = v;
      @(negedge clk_sys);
      wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [15:0] v);
      rd_addr = a;
      @(negedge clk_sys);
      v = rd_data;
   endtask : rd

   task automatic key(input logic [15:0] v);
      wr(`RPS_OSC_ADDR, 16'h0045);
      wr(`RPS_OSC_ADDR, 16'h0067);
      wr(`RPS_OSC_ADDR, v);
   endtask : key

   task automatic do_reset(input logic ow);
      sys_rst = 1'b1;
      one_way = ow;
      repeat (6) @(negedge clk_sys);
      sys_rst = 1'b0;
   endtask : do_reset

   initial begin
      @(negedge clk_sys);
      do_reset(1'b0);
      for (int i = 0; i < 14; i++) begin
         rd(IN_A[i], d);
         chk_word(d, 16'h0000, "input reg reset");
      end
      for (int k = 0; k < 8; k++) begin
         rd(`RPS_OUT_BASE + 6'(k), d);
         chk_word(d, 16'h0000, "output reg reset");
      end
      chk_flag(pin_map_lock, 1'b0, "lock reset");
      chk_word(pin_oe, 16'h0000, "no default pin");
      $display("test reset done");
      for (int i = 0; i < 14; i++) begin
         pin = (i == 13) ? 15 : i + 1;
         pad_level = 16'h0001 << pin;
         d = IN_HI[i] ? 16'(pin) << 8 : 16'(pin);
         wr(IN_A[i], d);
         rd(IN_A[i], wr_data);
         chk_word(wr_data, d, "input field readback");
         repeat (4) @(negedge clk_sys);
         chk_word(16'(ins), 16'h0001 << (13 - i), "input routing");
      end
      wr(6'h15, 16'(`RPS_TIE_GND));
      pad_level = 16'hffff;
      repeat (4) @(negedge clk_sys);
      chk_word(16'(ins), 16'h3ffe, "input tied low");
      analog_sel = 16'h0800;
      repeat (4) @(negedge clk_sys);
      chk_word(16'(ins), 16'h3ff6, "analog input wins");
      analog_sel = 16'h0000;
      $display("test inputs done");
      for (int p = 0; p < 2; p++) begin
         port_oe = p[0] ? 16'hffff : 16'h0000;
         port_out = p[0] ? 16'h0000 : 16'hffff;
         for (int r = 0; r < 10; r++) begin
            per_level = p[0] ? OHOT[r] : ~OHOT[r];
            wr(6'h21, 16'(OCODE[r]) << 8);
            repeat (2) @(negedge clk_sys);
            chk_flag(pin_oe[3], (OHOT[r] != 7'h00) | p[0], "output enable");
            chk_flag(pin_out[3], (OHOT[r] != 7'h00) ? p[0] : ~p[0], "output value");
         end
      end
      port_oe = 16'h0000;
      per_level = 7'h40;
      wr(6'h21, 16'h0300);
      analog_sel = 16'h0008;
      repeat (2) @(negedge clk_sys);
      chk_word({pin_oe[3], pin_out[3]}, 16'h0000, "analog output wins");
      analog_sel = 16'h0000;
      per_level = 7'h02;
      wr(6'h20, 16'h1212);
      repeat (2) @(negedge clk_sys);
      chk_word({pin_oe[1:0], pin_out[1:0]}, 16'h000f, "one output two pins");
      $display("test outputs done");
      key(16'h0040);
      chk_flag(pin_map_lock, 1'b1, "lock set");
      rd(`RPS_OSC_ADDR, d);
      chk_word(d, 16'h0040, "lock bit position");
      wr(6'h20, 16'h0909);
      rd(6'h20, d);
      chk_word(d, 16'h1212, "locked write ignored");
      wr(`RPS_OSC_ADDR, 16'h0045);
      wr(6'h00, 16'h0000);
      wr(`RPS_OSC_ADDR, 16'h0067);
      wr(`RPS_OSC_ADDR, 16'h0000);
      chk_flag(pin_map_lock, 1'b1, "broken sequence");
      key(16'h0000);
      chk_flag(pin_map_lock, 1'b0, "lock cleared");
      wr(6'h20, 16'h0303);
      wr(6'h21, 16'h0404);
      repeat (20) @(negedge clk_sys);
      chk_flag(pin_map_lock, 1'b0, "lock holds");
      rd(6'h20, d);
      chk_word(d, 16'h0303, "session write one");
      rd(6'h21, d);
      chk_word(d, 16'h0404, "session write two");
      $display("test lock done");
      do_reset(1'b1);
      chk_flag(pin_map_lock, 1'b0, "lock reset one way");
      key(16'h0040);
      key(16'h0000);
      chk_flag(pin_map_lock, 1'b1, "one way refuses clear");
      wr(6'h20, 16'h0707);
      rd(6'h20, d);
      chk_word(d, 16'h0000, "one way still locked");
      chk_flag(cfg_mismatch_rst, 1'b0, "no mismatch reset");
      $display("test one way done");
      wrap_up();
   end
endmodule : remappable_pin_select_tb_top
